/* src/rtc_pkg.sv */
// Shared constants for the countdown/event-log device and its I2C host
package rtc_pkg;
  // ****************************************************************
  // Device register map
  // ****************************************************************
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_IRQ_EN  = 8'h01;
  localparam logic [7:0] REG_LOG_CFG = 8'h05;
  localparam logic [7:0] REG_CD_CFG  = 8'h06;
  localparam logic [7:0] REG_CNT_HI  = 8'h19;
  localparam logic [7:0] REG_CNT_LO  = 8'h1a;
  localparam logic [7:0] REG_RLD_HI  = 8'h1b;
  localparam logic [7:0] REG_RLD_LO  = 8'h1c;
  localparam logic [7:0] REG_TS_BASE = 8'h30;
  localparam logic [7:0] REG_TS_LAST = 8'h4f;
  localparam int         TS_BYTES    = 32;
  localparam int         BANKS       = 4;
  localparam logic [2:0] FLAG_BYTE   = 3'h7;
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [15:0] RLD_RESET  = 16'h0000;
  // Field positions
  localparam int ST_TIMER   = 2;
  localparam int ST_PIN     = 3;
  localparam int ST_LOW     = 4;
  localparam int CD_RATE    = 0;
  localparam int CD_AUTO    = 2;
  localparam int CD_HOLD    = 3;
  localparam int CD_RUN     = 4;
  localparam int LG_ON      = 0;
  localparam int LG_CLEAR   = 1;
  localparam int LG_OVWR    = 2;
  localparam int LG_PIN     = 3;
  localparam int LG_SWAP    = 4;
  localparam int LG_LOW     = 5;
  localparam int LG_PIN_POL = 7;
  // Countdown tick periods in pclk cycles, one per rate code
  localparam int TICK_CYC0  = 16;
  localparam int TICK_CYC1  = 64;
  localparam int TICK_CYC2  = 256;
  localparam int TICK_CYC3  = 1024;
  localparam logic [6:0] I2C_ADDR = 7'h52;  // Arbitrary bus address
  // ****************************************************************
  // Host side
  // ****************************************************************
  localparam logic [7:0] H_CMD       = 8'h00;
  localparam logic [7:0] H_STAT      = 8'h04;
  localparam int         CLK_NS      = 10;
  localparam int         QUARTER_NS  = 2500;
  localparam int         QUARTER_CYC = QUARTER_NS / CLK_NS;
endpackage

/* src/rtc_link_if.sv */
// Two-wire link plus interrupt line between host and device
`timescale 1ns/1ps
interface rtc_link_if;
  logic scl_o;
  logic scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic irq_o;
  logic irq_oe;
  logic scl;
  logic sda;
  logic irq_n;

  // Open-drain resolution with pull-ups
  assign scl   = scl_oe ? scl_o : 1'b1;
  assign sda   = (h_sda_oe ? h_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);
  assign irq_n = irq_oe ? irq_o : 1'b1;

  modport dev (input scl, input sda, output d_sda_o, output d_sda_oe,
               output irq_o, output irq_oe);
  modport host (input sda, input irq_n, output scl_o, output scl_oe,
                output h_sda_o, output h_sda_oe);
endinterface

/* src/rtc_dev.sv */
// Device end: I2C register slave, countdown timer and event log
//
// Chosen here: the I2C interface to the registers.
`timescale 1ns/1ps
// Function
// [R1] Host loads reload pair before running
// [R2] Two-bit field selects tick rate
// [R3] Auto reload restarts from unchanged value
// [R4] Zero reached pulls irq low if enabled
// [R5] Hold only acts while run is set
// [R6] Host clears hold whenever clearing run
// [R7] Run and hold low keep counter reset
// [R8] Run set starts from reload value
// [R9] Run and hold freeze the count
// [R10] Hold released resumes from held value
// [R11] Four banks: seven time bytes, flags
// [R12] Capture pin edge, supply swaps, low backup
// [R13] No overwrite keeps first four events
// [R14] Overwrite replaces oldest, keeps newest four
// [R15] Capturing starts only with log on
// [R16] Clear zeroes banks, restarts at bank zero
// [R17] Log off makes banks plain RAM
// [R18] Host clears log after disabling it
// [R19] Banks readable at their own addresses
// [R20] Event sets status, status read clears
// [R21] Without reload counter parks at zero
// [R22] Bank flags mark only the trigger
module rtc_dev #(
  parameter int         TICK0 = rtc_pkg::TICK_CYC0,
  parameter int         TICK1 = rtc_pkg::TICK_CYC1,
  parameter int         TICK2 = rtc_pkg::TICK_CYC2,
  parameter int         TICK3 = rtc_pkg::TICK_CYC3,
  parameter logic [6:0] ADDR  = rtc_pkg::I2C_ADDR
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  rtc_link_if.dev          link,
  input  wire logic        event_pin,
  input  wire logic        on_backup,
  input  wire logic        backup_low,
  input  wire logic [55:0] time_now
);
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001, S_ADDR = 7'b0000010, S_AACK = 7'b0000100,
    S_WR   = 7'b0001000, S_WACK = 7'b0010000, S_RD   = 7'b0100000,
    S_RACK = 7'b1000000
  } i2c_st_t;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] scl_s, sda_s, pin_s, bak_s, low_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      pin_s <= 3'h0;
      bak_s <= 3'h0;
      low_s <= 3'h0;
    end else begin
      scl_s <= {scl_s[1:0], link.scl};
      sda_s <= {sda_s[1:0], link.sda};
      pin_s <= {pin_s[1:0], event_pin};
      bak_s <= {bak_s[1:0], on_backup};
      low_s <= {low_s[1:0], backup_low};
    end
  end
  // Only stages 1 and 2 are read; stage 0 feeds stage 1 alone
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign start_c  = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  assign stop_c   = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

  // ****************************************************************
  // Register state
  // ****************************************************************
  i2c_st_t     st_r;
  logic [3:0]  bit_r;
  logic [7:0]  sh_r, ptr_r, rd_data;
  logic        rnw_r, first_r, nack_r, sda_oe_r;
  logic [7:0]  status_r, irq_en_r, log_cfg_r, cd_cfg_r;
  logic [15:0] rld_r, cnt_r;
  logic [7:0]  ram_r [rtc_pkg::TS_BYTES];
  logic        wr_stb, rd_stb, clr_stb, in_ts;
  logic [4:0]  ts_idx;

  assign in_ts = (ptr_r >= rtc_pkg::REG_TS_BASE) &&
                 (ptr_r <= rtc_pkg::REG_TS_LAST);
  // Offset from the base, so bank b byte k is entry 8b+k
  assign ts_idx = 5'(ptr_r - rtc_pkg::REG_TS_BASE);
  // Byte taken once the eighth data bit has been shifted in
  assign wr_stb  = (st_r == S_WR) && scl_fall && (bit_r == 4'h8) &&
                   !first_r;
  // A transmit byte is fetched as its first bit goes out
  assign rd_stb  = scl_fall && (((st_r == S_AACK) && rnw_r) ||
                   ((st_r == S_RACK) && !nack_r));
  assign clr_stb = wr_stb && (ptr_r == rtc_pkg::REG_LOG_CFG) &&
                   sh_r[rtc_pkg::LG_CLEAR];

  // Read mux; clear bit always reads back as zero
  always_comb begin
    rd_data = 8'h00;
    case (ptr_r)
      rtc_pkg::REG_STATUS:  rd_data = status_r;
      rtc_pkg::REG_IRQ_EN:  rd_data = irq_en_r;
      rtc_pkg::REG_LOG_CFG: rd_data = log_cfg_r;
      rtc_pkg::REG_CD_CFG:  rd_data = cd_cfg_r;
      rtc_pkg::REG_CNT_HI:  rd_data = cnt_r[15:8];
      rtc_pkg::REG_CNT_LO:  rd_data = cnt_r[7:0];
      rtc_pkg::REG_RLD_HI:  rd_data = rld_r[15:8];
      rtc_pkg::REG_RLD_LO:  rd_data = rld_r[7:0];
      default: if (in_ts) rd_data = ram_r[ts_idx]; // see [R19]
    endcase
  end

  // ****************************************************************
  // I2C slave: start/stop win over any state, no clock stretching
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r     <= S_IDLE;
      bit_r    <= 4'h0;
      sh_r     <= 8'h00;
      ptr_r    <= 8'h00;
      rnw_r    <= 1'b0;
      first_r  <= 1'b0;
      nack_r   <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start_c) begin
      st_r     <= S_ADDR;
      bit_r    <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (stop_c) begin
      st_r     <= S_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        S_ADDR, S_WR: begin
          if (scl_rise && bit_r != 4'h8) begin
            sh_r  <= {sh_r[6:0], sda_s[2]};
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h8) begin
            if (st_r == S_WR) begin
              sda_oe_r <= 1'b1;
              st_r     <= S_WACK;
              first_r  <= 1'b0;
              if (first_r) ptr_r <= sh_r;
              else ptr_r <= ptr_r + 8'h01;
            end else if (sh_r[7:1] == ADDR) begin
              sda_oe_r <= 1'b1;
              rnw_r    <= sh_r[0];
              st_r     <= S_AACK;
            end else begin
              st_r <= S_IDLE;   // Not our address: stay off the bus
            end
          end
        end
        S_AACK, S_RACK: begin
          if (st_r == S_RACK && scl_rise) nack_r <= sda_s[2];
          if (rd_stb) begin
            sh_r     <= rd_data;
            sda_oe_r <= ~rd_data[7];
            ptr_r    <= ptr_r + 8'h01;
            bit_r    <= 4'h1;
            st_r     <= S_RD;
          end else if (scl_fall) begin
            sda_oe_r <= 1'b0;
            bit_r    <= 4'h0;
            first_r  <= (st_r == S_AACK);
            st_r     <= (st_r == S_AACK) ? S_WR : S_IDLE;
          end
        end
        S_WACK: if (scl_fall) begin
          sda_oe_r <= 1'b0;
          bit_r    <= 4'h0;
          st_r     <= S_WR;
        end
        S_RD: if (scl_fall) begin
          if (bit_r == 4'h8) begin
            sda_oe_r <= 1'b0;
            nack_r   <= 1'b1;
            st_r     <= S_RACK;
          end else begin
            sda_oe_r <= ~sh_r[6];
            sh_r     <= {sh_r[6:0], 1'b0};
            bit_r    <= bit_r + 4'h1;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r  <= rtc_pkg::CFG_RESET;
      log_cfg_r <= rtc_pkg::CFG_RESET;
      cd_cfg_r  <= rtc_pkg::CFG_RESET;
      rld_r     <= rtc_pkg::RLD_RESET;
    end else if (wr_stb) begin
      case (ptr_r)
        rtc_pkg::REG_IRQ_EN:  irq_en_r <= sh_r;
        rtc_pkg::REG_LOG_CFG: log_cfg_r <= sh_r & 8'hfd; // see [R15]
        rtc_pkg::REG_CD_CFG:  cd_cfg_r <= sh_r;
        rtc_pkg::REG_RLD_HI:  rld_r[15:8] <= sh_r;       // see [R1]
        rtc_pkg::REG_RLD_LO:  rld_r[7:0] <= sh_r;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Countdown timer
  // ****************************************************************
  logic        run, hold, done_r, zero_r, tick;
  logic [31:0] presc_r, tick_lim;
  assign run  = cd_cfg_r[rtc_pkg::CD_RUN];
  assign hold = cd_cfg_r[rtc_pkg::CD_HOLD] & run;   // see [R5]
  assign tick = (presc_r == tick_lim - 32'd1);

  // Rate select picks the prescaler period
  always_comb begin
    case (cd_cfg_r[rtc_pkg::CD_RATE +: 2])            // see [R2]
      2'h0:    tick_lim = 32'(TICK0);
      2'h1:    tick_lim = 32'(TICK1);
      2'h2:    tick_lim = 32'(TICK2);
      default: tick_lim = 32'(TICK3);
    endcase
  end

  // A pause freezes the prescaler too, so resume keeps phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r   <= rtc_pkg::RLD_RESET;
      presc_r <= 32'h0;
      done_r  <= 1'b0;
      zero_r  <= 1'b0;
    end else begin
      zero_r <= 1'b0;
      if (!run) begin
        cnt_r   <= rld_r;                             // see [R7]
        presc_r <= 32'h0;
        done_r  <= 1'b0;
      end else if (!hold && !done_r) begin            // see [R8] [R9]
        presc_r <= tick ? 32'h0 : presc_r + 32'h1;    // see [R10]
        if (tick && cnt_r <= 16'h0001) begin
          zero_r <= 1'b1;
          if (cd_cfg_r[rtc_pkg::CD_AUTO]) begin
            cnt_r <= rld_r;                           // see [R3]
          end else begin
            cnt_r  <= 16'h0000;                       // see [R21]
            done_r <= 1'b1;
          end
        end else if (tick) begin
          cnt_r <= cnt_r - 16'h0001;
        end
      end
    end
  end

  // ****************************************************************
  // Event detection and log
  // ****************************************************************
  logic [3:0] ev, ev_en, flag;
  logic [1:0] idx_r;
  logic [2:0] used_r;
  logic       pin_edge, cap;
  assign pin_edge = log_cfg_r[rtc_pkg::LG_PIN_POL] ?
                    (pin_s[1] & ~pin_s[2]) : (~pin_s[1] & pin_s[2]);
  assign ev = {low_s[1] & ~low_s[2], ~bak_s[1] & bak_s[2],
               bak_s[1] & ~bak_s[2], pin_edge};      // see [R12]
  assign ev_en = ev & {log_cfg_r[rtc_pkg::LG_LOW],
                       {2{log_cfg_r[rtc_pkg::LG_SWAP]}},
                       log_cfg_r[rtc_pkg::LG_PIN]};
  // Lowest bit wins when events coincide; the rest are dropped
  assign flag = ev_en & (~ev_en + 4'h1);                // see [R22]
  assign cap  = log_cfg_r[rtc_pkg::LG_ON] && (ev_en != 4'h0) &&
                (log_cfg_r[rtc_pkg::LG_OVWR] ||       // see [R14]
                 used_r != 3'(rtc_pkg::BANKS));        // see [R13]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < rtc_pkg::TS_BYTES; i++) ram_r[i] <= 8'h00;
      idx_r  <= 2'h0;
      used_r <= 3'h0;
    end else if (clr_stb) begin
      for (int i = 0; i < rtc_pkg::TS_BYTES; i++) ram_r[i] <= 8'h00;
      idx_r  <= 2'h0;                                 // see [R16]
      used_r <= 3'h0;
    end else if (cap) begin                           // see [R15]
      for (int k = 0; k < 7; k++)
        ram_r[{idx_r, 3'(k)}] <= time_now[8*k +: 8]; // see [R11]
      ram_r[{idx_r, rtc_pkg::FLAG_BYTE}] <= {4'h0, flag};
      idx_r <= idx_r + 2'h1;
      if (used_r != 3'(rtc_pkg::BANKS)) used_r <= used_r + 3'h1;
    end else if (wr_stb && in_ts && !log_cfg_r[rtc_pkg::LG_ON]) begin
      ram_r[ts_idx] <= sh_r;                          // see [R17]
    end
  end

  // ****************************************************************
  // Status and interrupt; a set in the clearing cycle survives
  // ****************************************************************
  logic [7:0] set_v, status_nxt;
  logic       irq_oe_r;
  assign set_v = {3'h0, ev[3], ev[0], zero_r, 2'h0};
  assign status_nxt = (rd_stb && ptr_r == rtc_pkg::REG_STATUS) ?
                      set_v : (status_r | set_v);     // see [R20]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= 8'h00;
      irq_oe_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq_oe_r <= |(status_nxt & irq_en_r);           // see [R4]
    end
  end

  assign link.d_sda_o  = 1'b0;
  assign link.d_sda_oe = sda_oe_r;
  assign link.irq_o    = 1'b0;
  assign link.irq_oe   = irq_oe_r;
endmodule

/* src/rtc_host.sv */
// Host end: APB-driven I2C controller issuing one-byte accesses
`timescale 1ns/1ps
module rtc_host #(
  parameter logic [6:0] ADDR = rtc_pkg::I2C_ADDR,
  parameter int         QCYC = rtc_pkg::QUARTER_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  rtc_link_if.host         link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001, H_START = 4'b0010, H_BIT = 4'b0100, H_STOP = 4'b1000
  } host_st_t;

  // ****************************************************************
  // Synchronisers and APB slave
  // ****************************************************************
  logic [1:0]  sda_s, irq_s;
  host_st_t    st_r;
  logic        rnw_r, nack_r, ack_r, go;
  logic [7:0]  reg_r, wdat_r, rdat_r, tx_r, rx_r;
  logic [2:0]  step_r;
  logic [3:0]  bit_r;
  logic [1:0]  q_r;
  logic [31:0] qc_r;
  logic        scl_oe_r, sda_oe_r, qtick, sda_val;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_s <= 2'h3;
      irq_s <= 2'h3;
    end else begin
      sda_s <= {sda_s[0], link.sda};
      irq_s <= {irq_s[0], link.irq_n};
    end
  end

  // Answer one cycle after setup; unmapped offsets flag an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr != rtc_pkg::H_CMD) &
                 (paddr != rtc_pkg::H_STAT);
      prdata  <= (paddr == rtc_pkg::H_STAT) ?
                 {15'h0, ~irq_s[1], rdat_r, 6'h0, nack_r,
                  st_r != H_IDLE} : 32'h0;
    end
  end
  // A command written while busy is ignored
  assign go = psel & penable & pready & pwrite &
              (paddr == rtc_pkg::H_CMD) & pwdata[0] & (st_r == H_IDLE);

  // Byte sent at each step: addr+W, reg, data or repeat, addr+R, read
  function automatic logic [7:0] step_byte(input logic [2:0] s);
    case (s)
      3'h0:    step_byte = {ADDR, 1'b0};
      3'h1:    step_byte = reg_r;
      3'h2:    step_byte = wdat_r;
      3'h3:    step_byte = {ADDR, 1'b1};
      default: step_byte = 8'hff;
    endcase
  endfunction

  // ****************************************************************
  // Bit engine: four quarters per slot, SCL low in first and last
  // ****************************************************************
  assign qtick = (qc_r == 32'(QCYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= H_IDLE;
      qc_r   <= 32'h0;
      q_r    <= 2'h0;
      step_r <= 3'h0;
      bit_r  <= 4'h0;
      tx_r   <= 8'h00;
      rx_r   <= 8'h00;
      ack_r  <= 1'b0;
      nack_r <= 1'b0;
      rnw_r  <= 1'b0;
      reg_r  <= 8'h00;
      wdat_r <= 8'h00;
      rdat_r <= 8'h00;
    end else if (st_r == H_IDLE) begin
      qc_r <= 32'h0;
      q_r  <= 2'h0;
      if (go) begin
        rnw_r  <= pwdata[1];
        reg_r  <= pwdata[15:8];
        wdat_r <= pwdata[23:16];
        nack_r <= 1'b0;
        step_r <= 3'h0;
        st_r   <= H_START;
      end
    end else begin
      qc_r <= qtick ? 32'h0 : qc_r + 32'h1;
      if (qtick) q_r <= q_r + 2'h1;
      if (qtick && q_r == 2'h1 && st_r == H_BIT) begin
        if (bit_r == 4'h8) ack_r <= sda_s[1];
        else rx_r <= {rx_r[6:0], sda_s[1]};
      end
      if (qtick && q_r == 2'h3) begin
        case (st_r)
          H_START: begin
            st_r  <= H_BIT;
            bit_r <= 4'h0;
            tx_r  <= step_byte(step_r);
          end
          H_BIT: begin
            if (bit_r != 4'h8) begin
              bit_r <= bit_r + 4'h1;
              tx_r  <= {tx_r[6:0], 1'b1};
            end else if (step_r != 3'h4 && ack_r) begin
              nack_r <= 1'b1;
              st_r   <= H_STOP;
            end else if (step_r == 3'h4 ||
                         (!rnw_r && step_r == 3'h2)) begin
              if (step_r == 3'h4) rdat_r <= rx_r;
              st_r <= H_STOP;
            end else begin
              step_r <= step_r + 3'h1;
              bit_r  <= 4'h0;
              tx_r   <= step_byte(step_r + 3'h1);
              if (rnw_r && step_r == 3'h1) st_r <= H_START;
            end
          end
          H_STOP:  st_r <= H_IDLE;
          default: st_r <= H_IDLE;
        endcase
        if (st_r == H_START && step_r == 3'h2) begin
          step_r <= 3'h3;
          tx_r   <= step_byte(3'h3);
        end
      end
    end
  end

  // Line level wanted in the current quarter
  always_comb begin
    case (st_r)
      H_START: sda_val = (q_r < 2'h2);
      H_STOP:  sda_val = (q_r >= 2'h2);
      H_BIT:   sda_val = (bit_r == 4'h8) | (step_r == 3'h4) | tx_r[7];
      default: sda_val = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      scl_oe_r <= (st_r != H_IDLE) && (q_r == 2'h0 || q_r == 2'h3);
      sda_oe_r <= ~sda_val;
    end
  end

  assign link.scl_o    = 1'b0;
  assign link.scl_oe   = scl_oe_r;
  assign link.h_sda_o  = 1'b0;
  assign link.h_sda_oe = sda_oe_r;
endmodule

/* tb/rtc_properties.sv */
// Link checks between the host and device ends
`timescale 1ns/1ps
module rtc_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic irq_n,
  input wire logic scl_oe,
  input wire logic d_sda_oe,
  input wire logic irq_oe
);
  // ****
  // Link and interrupt line
  // ****
  // One domain, so one clock and one reset for every check
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A raised irq stays asserted for at least the eight cycles after it rises
  AST_IRQ_HOLD: assert property ($rose(irq_oe) |=> irq_oe[*8])
    else $error("irq released early");
  // Open-drain data output may only pull low
  AST_SDA_OD: assert property (d_sda_oe |-> !sda)
    else $error("sda not low");
  // A status read frees irq while SCL is held low
  AST_IRQ_CLR: assert property ($fell(irq_oe) |-> scl_oe)
    else $error("irq freed off access");
  // Device data moves only under a low SCL
  AST_SDA_MOVE: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("sda moved, scl high");
  AST_SDA_HOLD: assert property ($rose(d_sda_oe) |-> d_sda_oe[*8])
    else $error("sda bit short");
  AST_SCL_LOW: assert property ($rose(scl_oe) |=> scl_oe[*7])
    else $error("scl low short");
  AST_SCL_HIGH: assert property ($fell(scl_oe) |=> (!scl_oe)[*7])
    else $error("scl high short");
  // Nothing pulls a line at the first edge out of reset
  AST_RST_IDLE: assert property
    ($rose(presetn) |-> !(scl_oe || d_sda_oe || irq_oe))
    else $error("line driven at reset");
endmodule

/* tb/testbench.sv */
// Bench joining host and device, driving APB and event inputs
`timescale 1ns/1ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, serr, irq;
  logic        pready, pslverr, event_pin, on_backup, backup_low;
  logic [7:0]  paddr, q, a;
  logic [7:0]  d [4];
  logic [31:0] pwdata, prdata;
  logic [55:0] time_now;
  int          err_count, checks, cyc;
  rtc_link_if lnk ();
  rtc_dev #(.TICK0(8), .TICK1(32), .TICK2(128), .TICK3(512)) rtc_dev_i (
    .pclk(pclk), .presetn(presetn), .link(lnk.dev), .event_pin(event_pin),
    .on_backup(on_backup), .backup_low(backup_low), .time_now(time_now));
  rtc_host #(.QCYC(8)) rtc_host_i (.pclk(pclk), .presetn(presetn),
    .link(lnk.host), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  rtc_properties rtc_properties_i (.pclk(pclk), .presetn(presetn),
    .scl(lnk.scl), .sda(lnk.sda), .irq_n(lnk.irq_n), .scl_oe(lnk.scl_oe),
    .d_sda_oe(lnk.d_sda_oe), .irq_oe(lnk.irq_oe));
  // ****
  // Bus tasks
  // ****
  // Compare and count
  task automatic chk(input logic [7:0] g, e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // One APB transfer; the extra edge keeps psel from toggling in a step
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd, output logic [31:0] rv);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the slave; only the hang guard ends a stuck access
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // One device register access, polled until the link is idle
  task automatic dev(input logic w, input logic [7:0] r, dt);
    logic [31:0] v;
    apb(1'b1, rtc_pkg::H_CMD, {8'h00, dt, r, 6'h00, ~w, 1'b1}, v);
    do apb(1'b0, rtc_pkg::H_STAT, 32'h0, v); while (v[0] !== 1'b0);
    q = v[15:8];
    irq = v[16];
    chk({7'h00, v[1]}, 8'h00);
  endtask
  task automatic wr(input logic [7:0] r, dt);
    dev(1'b1, r, dt);
  endtask
  task automatic rd(input logic [7:0] r);
    dev(1'b0, r, 8'h00);
  endtask
  // Event pin pulse, long enough for the input synchroniser
  task automatic pin(input logic [7:0] k);
    time_now <= {48'h0, k};
    @(posedge pclk);
    event_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    event_pin <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  // ****
  // Scenarios
  // ****
  // Reset value, bad offset, one-shot expiry and irq clearing
  task automatic t_timer();
    logic [31:0] v;
    rd(rtc_pkg::REG_CD_CFG);
    chk(q, rtc_pkg::CFG_RESET);
    apb(1'b0, 8'h08, 32'h0, v);
    chk({7'h00, serr}, 8'h01);
    wr(rtc_pkg::REG_RLD_LO, 8'h03);
    wr(rtc_pkg::REG_IRQ_EN, 8'h04);
    wr(rtc_pkg::REG_CD_CFG, 8'h10);
    rd(rtc_pkg::REG_CNT_LO);
    chk(q, 8'h00);
    chk({7'h00, irq}, 8'h01);
    rd(rtc_pkg::REG_STATUS);
    chk(q, 8'h04);
    chk({7'h00, irq}, 8'h00);
  endtask
  // Pause keeps the count, resume continues from it
  task automatic t_hold();
    wr(rtc_pkg::REG_CD_CFG, 8'h00);
    wr(rtc_pkg::REG_RLD_LO, 8'hc8);
    rd(rtc_pkg::REG_CNT_LO);
    chk(q, 8'hc8);
    wr(rtc_pkg::REG_CD_CFG, 8'h11);
    rd(rtc_pkg::REG_CNT_LO);
    chk(8'(q < 8'hc8 && q > 0), 8'h01);
    wr(rtc_pkg::REG_CD_CFG, 8'h19);
    rd(rtc_pkg::REG_CNT_LO);
    a = q;
    rd(rtc_pkg::REG_CNT_LO);
    chk(q, a);
    wr(rtc_pkg::REG_CD_CFG, 8'h11);
    rd(rtc_pkg::REG_CNT_LO);
    chk(8'(q < a), 8'h01);
  endtask
  // Faster rate codes drain more counts in the same window
  task automatic t_rate();
    wr(rtc_pkg::REG_CD_CFG, 8'h00);
    wr(rtc_pkg::REG_RLD_HI, 8'h0f);
    wr(rtc_pkg::REG_RLD_LO, 8'hff);
    for (int r = 0; r < 4; r++) begin
      wr(rtc_pkg::REG_CD_CFG, 8'(r));
      wr(rtc_pkg::REG_CD_CFG, 8'(16 + r));
      rd(rtc_pkg::REG_CNT_LO);
      a = q;
      rd(rtc_pkg::REG_CNT_LO);
      d[r] = a - q;
    end
    for (int r = 0; r < 3; r++)
      chk(8'(d[r] > d[r+1]), 8'h01);
    wr(rtc_pkg::REG_CD_CFG, 8'h00);
    wr(rtc_pkg::REG_RLD_HI, 8'h00);
    wr(rtc_pkg::REG_RLD_LO, 8'h03);
    wr(rtc_pkg::REG_CD_CFG, 8'h14);
    rd(rtc_pkg::REG_CNT_LO);
    chk(8'(q != 0 && q <= 3), 8'h01);
  endtask
  // Stop and overwrite policies, clear, supply events and plain RAM
  task automatic t_log();
    wr(rtc_pkg::REG_LOG_CFG, 8'h89);
    for (int k = 1; k < 6; k++)
      pin(8'(k));
    for (int b = 0; b < 4; b++) begin
      rd(8'(rtc_pkg::REG_TS_BASE + 8 * b));
      chk(q, 8'(b + 1));
    end
    rd(rtc_pkg::REG_TS_BASE + 8'h07);
    chk(q, 8'h01);
    wr(rtc_pkg::REG_LOG_CFG, 8'h8f);
    rd(rtc_pkg::REG_TS_BASE);
    chk(q, 8'h00);
    for (int k = 1; k < 7; k++)
      pin(8'(k));
    for (int b = 0; b < 4; b++) begin
      rd(8'(rtc_pkg::REG_TS_BASE + 8 * b));
      chk(q, 8'(b < 2 ? b + 5 : b + 1));
    end
    wr(rtc_pkg::REG_LOG_CFG, 8'h33);
    on_backup <= 1'b1;
    repeat (8) @(posedge pclk);
    on_backup <= 1'b0;
    repeat (8) @(posedge pclk);
    backup_low <= 1'b1;
    repeat (8) @(posedge pclk);
    for (int b = 0; b < 3; b++) begin
      rd(8'(rtc_pkg::REG_TS_BASE + 8 * b + 7));
      chk(q, 8'(2 << b));
    end
    wr(rtc_pkg::REG_LOG_CFG, 8'h02);
    wr(rtc_pkg::REG_TS_LAST, 8'ha5);
    rd(rtc_pkg::REG_TS_LAST);
    chk(q, 8'ha5);
  endtask
  // Verdict and end of run
  task automatic results();
    $display("Checks %0d, errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard, well above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      $display("Error at %0t: timeout", $time);
      results();
    end
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, event_pin, on_backup} = 6'h00;
    {backup_low, paddr, pwdata, time_now} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_timer();
    t_hold();
    t_rate();
    t_log();
    results();
  end
endmodule
